// ==== logic/crs_sequencer.sv ====
// crs_sequencer: up/down ring rom sequencer, dual select path, out fifo
// assumes: i_sync and select inputs synchronous to i_ref_clk
// Behaviour
// (RULE1) rom holds seventeen eight-bit words
// (RULE2) separate cosine and sine rom copies
// (RULE3) external word when ext high, int low
// (RULE4) two independent select paths with outputs
// (RULE5) programmed cell reads zero, else one
// (RULE6) rom walked forward then backward
// (RULE7) exactly one word line active
// (RULE8) outputs forced high during precharge phase
// (RULE9) word valid only after precharge phase
// (RULE10) seventeen-stage reversible shift register
// (RULE11) sample phase then update phase
// (RULE12) stage output is input one cycle earlier
// (RULE13) single one bounces across all stages
// (RULE14) only one stage holds a one
// (RULE15) direction bit; forward feeds next stage
// (RULE16) one at last stage flips to reverse
// (RULE17) reverse: next-to-last next, zero enters last
// (RULE18) first stage: forward, second next, zero first
// (RULE19) external sync pulse realigns position
// (RULE20) all-zero register sets first stage
// (RULE21) one at first stage forces second only
// (RULE22) sync sets second stage and forward
// (RULE23) words are two's complement fractions
// (RULE24) registered model, one word per cycle
`timescale 1ns/1ns

// ****************************************
// fifo
// ****************************************
module crs_fifo
  import crs_pkg::*;
#(
  parameter int WIDTH = 2 * CRS_BITS,
  parameter int DEPTH = CRS_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);

  // pointer compare with one spare bit needs a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_geom
    $error("crs_fifo: depth must be a power of two >= 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  // one extra pointer bit tells full from empty
  logic [AW:0] wr_reg;
  logic [AW:0] wr_next;
  logic [AW:0] rd_reg;
  logic [AW:0] rd_next;
  // head word registered, refetched on every pop
  logic [WIDTH-1:0] out_reg;
  logic [WIDTH-1:0] out_next;
  logic push;
  logic pop;

  always_comb begin
    o_ready = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    o_valid = wr_reg != rd_reg;
    push = i_valid && o_ready && i_ce;
    pop = o_valid && i_ready && i_ce;
    mem_next = mem_reg;
    wr_next = wr_reg;
    rd_next = rd_reg;
    if (push) begin
      mem_next[wr_reg[AW-1:0]] = i_data;
      wr_next = wr_reg + (AW+1)'(1);
    end
    if (pop)
      rd_next = rd_reg + (AW+1)'(1);
    out_next = mem_next[rd_next[AW-1:0]];
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_reg <= '0;
      rd_reg <= '0;
      out_reg <= '0;
    end else if (i_ce) begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      out_reg <= out_next;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_ce)
      mem_reg <= mem_next;
  end

  assign o_data = out_reg;
endmodule : crs_fifo

// ****************************************
// sequencer top
// ****************************************
module crs_sequencer
  import crs_pkg::*;
#(
  parameter int FIFO_DEPTH = CRS_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_sync,
  input wire logic [1:0] i_int_sel,
  input wire logic [1:0] i_ext_sel,
  input wire crs_pair_t i_ext_word_a,
  input wire crs_pair_t i_ext_word_b,
  output logic o_valid,
  input wire logic i_ready,
  output crs_pair_t o_word_a,
  output crs_pair_t o_word_b,
  output logic [CRS_WORDS-1:0] o_word_line,
  output logic o_direction,
  output logic [CRS_BITS-1:0] o_cos_rom,
  output logic [CRS_BITS-1:0] o_sin_rom
);
  logic [CRS_WORDS-1:0] ring_reg, ring_next; // [RULE10]
  crs_dir_t dir_reg, dir_next;
  logic [CRS_WORDS-1:0] shifted;
  crs_pair_t rom_reg, rom_next;
  crs_pair_t sel_a, sel_b;
  logic stall;
  logic fifo_ready;
  logic ring_empty;
  logic at_first;
  logic at_last;
  logic primed_reg;
  logic primed_next;

  // ****************************************
  // parameter check
  // ****************************************
  if (FIFO_DEPTH < 2) begin : g_bad_depth
    $error("crs_sequencer: fifo depth must be at least two");
  end

  // ****************************************
  // ring counter
  // ****************************************
  // every stage advances on the same edge: sampled, then updated [RULE11]
  // a full fifo holds ring and rom together so no word is lost
  assign stall = !fifo_ready;

  // decoded ring positions that steer the next state
  assign ring_empty = ring_reg == CRS_RING_ZERO;
  assign at_first = ring_reg[CRS_FIRST];
  assign at_last = ring_reg[CRS_LAST];

  // sync beats every other case: a stray pulse realigns on any cycle with i_ce high and the fifo not full,
  // and a lost one is recovered by the end detectors
  always_comb begin
    dir_next = dir_reg;
    if (dir_reg == CRS_DIR_FWD)
      shifted = {ring_reg[CRS_WORDS-2:0], 1'b0}; // [RULE15] [RULE12]
    else
      shifted = {1'b0, ring_reg[CRS_WORDS-1:1]}; // [RULE17]
    ring_next = shifted;
    if (i_sync) begin
      ring_next = CRS_RING_SECOND; // [RULE22] [RULE19]
      dir_next = CRS_DIR_FWD;
    end else if (ring_empty) begin
      ring_next = CRS_RING_RST; // [RULE20]
    end else if (at_first) begin
      ring_next = CRS_RING_SECOND; // [RULE21] [RULE18] [RULE14]
      dir_next = CRS_DIR_FWD;
    end else if (at_last) begin
      dir_next = CRS_DIR_REV; // [RULE16] [RULE13] [RULE6]
      ring_next = {1'b0, ring_reg[CRS_WORDS-1:1]};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ring_reg <= CRS_RING_RST;
      dir_reg <= CRS_DIR_FWD;
    end else if (i_ce && !stall) begin
      ring_reg <= ring_next;
      dir_reg <= dir_next;
    end
  end

  assign o_word_line = ring_reg; // [RULE7]
  assign o_direction = dir_reg;

  // ****************************************
  // rom read
  // ****************************************
  // precharge to all ones, programmed cells pull low [RULE5] [RULE8]
  always_comb begin
    rom_next.cos_word = CRS_PRECHARGE;
    rom_next.sin_word = CRS_PRECHARGE;
    for (int j = 0; j < CRS_WORDS; j++) begin
      if (ring_reg[j]) begin
        rom_next.cos_word = rom_next.cos_word & ~CRS_COS_CELLS[j]; // [RULE1]
        rom_next.sin_word = rom_next.sin_word & ~CRS_SIN_CELLS[j]; // [RULE2]
      end
    end
  end

  // word registered once evaluation done: valid next cycle [RULE9] [RULE24]
  always_ff @(posedge i_ref_clk) begin
    if (i_rst)
      rom_reg <= '{cos_word: CRS_PRECHARGE, sin_word: CRS_PRECHARGE};
    else if (i_ce && !stall)
      rom_reg <= rom_next;
  end

  assign o_cos_rom = rom_reg.cos_word;
  assign o_sin_rom = rom_reg.sin_word;

  // ****************************************
  // word primed flag
  // ****************************************
  // rom_reg holds the precharge value until the first evaluation;
  // nothing reaches the fifo before a real word stands [RULE9]
  always_comb begin
    primed_next = primed_reg;
    if (i_ce && !stall)
      primed_next = 1'b1;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst)
      primed_reg <= 1'b0;
    else
      primed_reg <= primed_next;
  end

  // ****************************************
  // select paths
  // ****************************************
  localparam int PATHS = 2;
  localparam logic [1:0] SEL_EXT = 2'h2;
  localparam logic [1:0] SEL_INT = 2'h1;
  crs_pair_t ext_word [PATHS];
  crs_pair_t path_word [PATHS];

  assign ext_word[0] = i_ext_word_a;
  assign ext_word[1] = i_ext_word_b;

  // two paths, each own select pair and word [RULE4]
  // both selects equal: word forced to zero rather than a mix
  for (genvar p = 0; p < PATHS; p++) begin : g_path
    crs_pair_t word_sel;
    always_comb begin
      case ({i_ext_sel[p], i_int_sel[p]})
        SEL_EXT: begin
          word_sel = ext_word[p]; // [RULE3]
        end
        SEL_INT: begin
          word_sel = rom_reg;
        end
        default: begin
          word_sel = '0;
        end
      endcase
    end
    assign path_word[p] = word_sel;
  end

  assign sel_a = path_word[0];
  assign sel_b = path_word[1];

  // words pass as two's complement fractions to the dacs [RULE23]
  crs_fifo #(
    .WIDTH(4 * CRS_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_valid(primed_reg),
    .o_ready(fifo_ready),
    .i_data({sel_a, sel_b}),
    .o_valid(o_valid),
    .i_ready(i_ready),
    .o_data({o_word_a, o_word_b})
  );
endmodule : crs_sequencer

// ==== logic/crs_pkg.sv ====
// crs_pkg: constants and carrier types for the chirp rom sequencer
// assumes: single 25 MHz clock domain, synchronous active-high reset
package crs_pkg;

  // ****************************************
  // geometry
  // ****************************************
  localparam int CRS_WORDS = 17;
  localparam int CRS_BITS = 8;
  localparam int CRS_PERIOD = 32;
  localparam int CRS_FIFO_DEPTH = 32;
  localparam int CRS_FIRST = 0;
  localparam int CRS_SECOND = 1;
  localparam int CRS_LAST = CRS_WORDS - 1;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [CRS_WORDS-1:0] CRS_RING_RST = 17'h00001;
  localparam logic [CRS_WORDS-1:0] CRS_RING_ZERO = 17'h00000;
  localparam logic [CRS_WORDS-1:0] CRS_RING_SECOND = 17'h00002;
  localparam logic [CRS_BITS-1:0] CRS_PRECHARGE = 8'hFF;

  typedef enum logic [0:0] {
    CRS_DIR_FWD = 1'b0,
    CRS_DIR_REV = 1'b1
  } crs_dir_t;

  // one word for each dac pair
  typedef struct packed {
    logic [CRS_BITS-1:0] cos_word;
    logic [CRS_BITS-1:0] sin_word;
  } crs_pair_t;

  // stored cell pattern: 1 = cell programmed (reads zero)
  typedef logic [CRS_BITS-1:0] crs_rom_t [CRS_WORDS];

  // cosine table, cells stored as programmed-mask (inverted words)
  localparam crs_rom_t CRS_COS_CELLS = '{
    8'h80, 8'h81, 8'h85, 8'h8F, 8'hA5, 8'hCE, 8'hFD, 8'h3D, 8'h80,
    8'hCE, 8'h3E, 8'hFE, 8'h30, 8'h4E, 8'hF2, 8'h01, 8'h80};
  // sine table, from the printed sine chirp
  localparam crs_rom_t CRS_SIN_CELLS = '{
    8'hFF, 8'hF3, 8'hCE, 8'h9D, 8'h80, 8'hAE, 8'h30, 8'h7D, 8'hFF,
    8'h81, 8'h30, 8'h50, 8'h80, 8'h61, 8'hCE, 8'h0B, 8'hFF};

endpackage : crs_pkg

// ==== sim/crs_dac_sink.sv ====
// crs_dac_sink: dac drive side, takes fifo words, may stall
// assumes: bench drives i_stall at the falling edge
`timescale 1ns/1ns
module crs_dac_sink
  import crs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_ce,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire crs_pair_t i_word_a,
  input wire crs_pair_t i_word_b,
  output logic o_ready,
  output logic o_took,
  output crs_pair_t o_word_a,
  output crs_pair_t o_word_b
);
  // word read only after the precharge phase: taken at the edge
  // one clock edge per word: sample then update
  always_comb o_ready = !i_stall;
  always @(posedge i_ref_clk) begin
    o_took <= i_valid && o_ready && i_ce;
    o_word_a <= i_word_a;
    o_word_b <= i_word_b;
  end
endmodule : crs_dac_sink

// ==== sim/crs_sequencer_asserts.sv ====
// crs_sequencer_asserts: ring and rom relations at the top ports
// assumes: bound into crs_sequencer, one clock domain
`timescale 1ns/1ns
module crs_sequencer_asserts
  import crs_pkg::*;
#(
  parameter int FIFO_DEPTH = CRS_FIFO_DEPTH
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_sync,
  input wire logic o_valid,
  input wire logic [CRS_WORDS-1:0] o_word_line,
  input wire logic o_direction,
  input wire logic [CRS_BITS-1:0] o_cos_rom,
  input wire logic [CRS_BITS-1:0] o_sin_rom
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [4:0] pos;
  always_comb begin
    pos = 5'h00;
    for (int i = 0; i < CRS_WORDS; i++) if (o_word_line[i]) pos = 5'(i);
  end
  one_hot_a: assert property ($onehot(o_word_line))
    else $error("word lines not one-hot");
  fwd_step_a: assert property (
    !i_sync && !o_direction && !o_word_line[16]
    ##1 $changed(o_word_line) |-> o_word_line == $past(o_word_line) << 1)
    else $error("forward step wrong");
  rev_step_a: assert property (
    !i_sync && o_direction && !o_word_line[0]
    ##1 $changed(o_word_line) |-> o_word_line == $past(o_word_line) >> 1)
    else $error("reverse step wrong");
  last_turn_a: assert property (!i_sync && o_word_line[16]
    ##1 $changed(o_word_line) |-> o_word_line[15] && o_direction)
    else $error("no turn at last stage");
  first_turn_a: assert property (
    !i_sync && o_word_line[0] ##1 $changed(o_word_line)
    |-> o_word_line == CRS_RING_SECOND && !o_direction)
    else $error("no turn at first stage");
  sync_pos_a: assert property (i_sync && i_ce |=>
    o_word_line == CRS_RING_SECOND && o_direction == CRS_DIR_FWD)
    else $error("sync did not realign");
  ce_freeze_a: assert property (!i_ce |=> $stable(o_word_line)
    && $stable(o_direction) && $stable(o_valid))
    else $error("state moved while disabled");
  rom_word_a: assert property ($changed(o_word_line) |->
    o_cos_rom == ~CRS_COS_CELLS[$past(pos)]
    && o_sin_rom == ~CRS_SIN_CELLS[$past(pos)])
    else $error("rom word mismatch");
  cover property (i_sync && i_ce);
  cover property (o_word_line[16] ##1 o_word_line[15]);
  cover property (o_word_line[0] && o_direction);
endmodule : crs_sequencer_asserts

// ==== sim/crs_sequencer_bench.sv ====
// crs_sequencer_bench: self-checking bench for the chirp rom sequencer
// assumes: crs_pkg, crs_sequencer, crs_dac_sink, crs_sequencer_asserts
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
  fail_count++; $display("[FAIL] %0t %0h %0h", $time, a, b); end end
module crs_sequencer_bench;
  import crs_pkg::*;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, sync = 1'b0, stall = 1'b0;
  logic [1:0] int_sel = 2'h3, ext_sel = 2'h0;
  crs_pair_t ea = 16'hA55A, eb = 16'h3CC3, ta, tb, wa, wb;
  logic valid, ready, took, dir;
  logic [CRS_WORDS-1:0] wl, hold;
  int fail_count = 0, comparisons = 0, k = 0;
  always #20 clk = ~clk;
  crs_sequencer i_crs_sequencer (.i_ref_clk(clk), .i_rst(rst), .i_ce(ce),
    .i_sync(sync), .i_int_sel(int_sel), .i_ext_sel(ext_sel),
    .i_ext_word_a(ea), .i_ext_word_b(eb), .o_valid(valid), .i_ready(ready),
    .o_word_a(wa), .o_word_b(wb), .o_word_line(wl), .o_direction(dir),
    .o_cos_rom(), .o_sin_rom());
  crs_dac_sink i_crs_dac_sink (.i_ref_clk(clk), .i_ce(ce), .i_stall(stall),
    .i_valid(valid), .i_word_a(wa), .i_word_b(wb), .o_ready(ready),
    .o_took(took), .o_word_a(ta), .o_word_b(tb));
  function automatic crs_pair_t expw(int p);
    return {~CRS_COS_CELLS[p], ~CRS_SIN_CELLS[p]};
  endfunction : expw
  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  task automatic wait_took();
    int n;
    n = 0;
    do begin @(negedge clk); n++; end while (took !== 1'b1 && n < 80);
    if (took !== 1'b1) begin fail_count++; print_verdict(); end
  endtask : wait_took
  task automatic do_reset();
    rst = 1'b1;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    k = 0;
  endtask : do_reset
  task automatic walk(int n);
    int m;
    repeat (n) begin
      wait_took();
      m = k % CRS_PERIOD;
      m = (m <= CRS_LAST) ? m : CRS_PERIOD - m;
      `CHK(ta, expw(m))
      `CHK(tb, expw(m))
      k++;
    end
  endtask : walk
  task automatic stall_fill();
    stall = 1'b1;
    repeat (60) @(negedge clk);
    hold = wl;
    repeat (5) @(negedge clk);
    `CHK(wl, hold)
    stall = 1'b0;
    walk(40);
  endtask : stall_fill
  task automatic freeze();
    ce = 1'b0;
    hold = wl;
    repeat (4) @(negedge clk);
    `CHK(wl, hold)
    ce = 1'b1;
  endtask : freeze
  task automatic pulse_sync();
    sync = 1'b1;
    @(negedge clk);
    sync = 1'b0;
    `CHK(wl, CRS_RING_SECOND)
    `CHK(dir, 1'(CRS_DIR_FWD))
  endtask : pulse_sync
  task automatic sel(logic [1:0] si, logic [1:0] se, crs_pair_t xa,
                     crs_pair_t xb);
    int_sel = si;
    ext_sel = se;
    do_reset();
    wait_took();
    `CHK(ta, xa)
    `CHK(tb, xb)
  endtask : sel
  initial begin
    do_reset();
    walk(40);
    stall_fill();
    freeze();
    pulse_sync();
    sel(2'h2, 2'h1, ea, expw(0));
    sel(2'h1, 2'h2, expw(0), eb);
    sel(2'h3, 2'h3, 16'h0000, 16'h0000);
    print_verdict();
  end
endmodule : crs_sequencer_bench
bind crs_sequencer crs_sequencer_asserts #(.FIFO_DEPTH(FIFO_DEPTH))
  i_crs_sequencer_asserts (.i_ref_clk, .i_rst, .i_ce, .i_sync, .o_valid,
  .o_word_line, .o_direction, .o_cos_rom, .o_sin_rom);
